// ---- core/urc_uart_regs.sv ----
// UART channel register map, interrupt status and line status
// Notes on behaviour
// - Divisor low/high bytes sit at addresses 0 and 1 while divisor enable is set and line control is not the enhanced key.
// - Enhanced enable, FIFO and modem bits act only with enhanced bit 4 set.
// - Enable register gates rx, tx, line and modem sources into interrupt status.
// - FIFO mode rx interrupt rises at trigger level, drops below it.
// - Status code for trigger reached clears with output when fill drops below.
// - Data ready sets when a character enters the FIFO, clears when empty.
// - Receive and transmit indications occupy separate line status bits.
// - Line status bit 1 flags a receive overrun.
// - Line status bits 2-4 show errors of the head byte, else zero.
// - Line status bit 5 set while transmit holding is empty.
// - Line status bit 6 set only when transmit FIFO and shifter are empty.
// - Line status bit 7 set while any FIFO character carries an error.
// - Pending tx interrupt clears on status read or transmit byte write.
// - Enabling tx interrupt while holding is empty raises it at once.
`timescale 1ns/1ns
module urc_uart_regs
  import urc_pkg::*;
#(
  parameter logic [7:0] SILICON_REV = 8'h01, // Arbitrary value
  parameter logic [7:0] PART_ID     = 8'h5A  // Arbitrary value
)(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  output logic             irq_o,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic [2:0]  rx_err_i,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_data_o,
  input  wire logic        tx_ready_i,
  input  wire logic        tx_shift_empty_i,
  input  wire logic [3:0]  modem_lines_i,
  input  wire logic [3:0]  modem_delta_i,
  output logic      [15:0] divisor_o,
  output logic      [7:0]  line_control_o
);
  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] fifo_control;
    logic [7:0] modem_control;
    logic [7:0] scratch;
    logic [7:0] baud_divisor_low;
    logic [7:0] baud_divisor_high;
    logic [7:0] feature_control;
    logic [7:0] enhanced_function;
    logic [7:0] rx_trigger_level;
    logic [7:0] tx_trigger_level;
    logic [7:0] flow_resume_char_1;
    logic [7:0] flow_resume_char_2;
    logic [7:0] flow_pause_char_1;
    logic [7:0] flow_pause_char_2;
    logic       overrun;
    logic       tx_int;
    logic       tx_need_q;
    logic [3:0] delta;
    logic [6:0] err_cnt;
    logic [7:0] rdata;
    logic       irq;
  } urc_regs_s;

  urc_regs_s         st;
  urc_regs_s         next_st;
  logic              enh;
  logic              div_sel;
  logic              norm;
  logic              efr_on;
  logic              fifo_on;
  logic [7:0]        ie_eff;
  logic [7:0]        fctl_eff;
  logic [7:0]        mctl_eff;
  logic [7:0]        rx_trig;
  logic [7:0]        tx_trig;
  logic [7:0]        lstat;
  logic [7:0]        istat;
  logic [5:0]        int_code;
  logic [RX_W-1:0]   rx_head;
  logic [TX_W-1:0]   tx_head;
  logic [6:0]        rx_cnt;
  logic [6:0]        tx_cnt;
  logic              rx_full;
  logic              rx_empty;
  logic              tx_full;
  logic              tx_empty;
  logic              rx_full_eff;
  logic              tx_full_eff;
  logic              rx_push;
  logic              rx_pop;
  logic              rx_clr;
  logic              tx_push;
  logic              tx_pop;
  logic              tx_clr;
  logic              tx_need;
  logic              buf_ready;
  logic              fctl_wr;
  logic              ie_tx_rise;
  logic              line_src;
  logic              rx_src;
  logic              tx_src;
  logic              modem_src;

  assign enh     = st.line_control == LINE_CTL_ENH_KEY;
  assign div_sel = st.line_control[DIV_EN_BIT] && !enh;
  assign norm    = !enh && !div_sel;
  assign efr_on  = st.enhanced_function[ENH_EN_BIT];
  assign fifo_on = st.fifo_control[FIFO_EN_BIT];

  // Enhanced bits stay stored but have no effect while the enhanced gate is shut
  assign ie_eff   = efr_on ? st.interrupt_enable_reg : st.interrupt_enable_reg & ~IE_ENH_MASK;
  assign fctl_eff = efr_on ? st.fifo_control : st.fifo_control & ~FIFO_CTL_ENH_MASK;
  assign mctl_eff = efr_on ? st.modem_control : st.modem_control & ~MODEM_CTL_ENH_MASK;

  assign rx_trig = (st.feature_control[5:4] == TRIG_CUSTOM) ? st.rx_trigger_level : RX_TRIG_TAB[fctl_eff[7:6]];
  assign tx_trig = (st.feature_control[5:4] == TRIG_CUSTOM) ? st.tx_trigger_level : TX_TRIG_TAB[fctl_eff[5:4]];

  // Without FIFOs each direction behaves as a one-byte holding position
  assign rx_full_eff = fifo_on ? rx_full : !rx_empty;
  assign tx_full_eff = fifo_on ? tx_full : !tx_empty;

  assign fctl_wr = wr_i && !enh && addr_i == ADDR_FIFO_CTL;
  assign rx_clr  = fctl_wr && wdata_i[FIFO_EN_BIT] && wdata_i[RX_RST_BIT];
  assign tx_clr  = fctl_wr && wdata_i[FIFO_EN_BIT] && wdata_i[TX_RST_BIT];
  assign rx_push = rx_valid_i && !rx_full_eff && !rx_clr;
  assign rx_pop  = rd_i && norm && addr_i == ADDR_HOLD && !rx_empty;
  assign tx_push = wr_i && norm && addr_i == ADDR_HOLD && !tx_full_eff;
  assign tx_pop  = !tx_empty && buf_ready && !tx_clr;
  assign tx_need = fifo_on ? ({1'b0, tx_cnt} < tx_trig) : tx_empty;
  assign ie_tx_rise = wr_i && norm && addr_i == ADDR_INT_EN && wdata_i[IE_TX_BIT] && !ie_eff[IE_TX_BIT];

  // Receive bits 0-4 and 7, transmit bits 5-6, so each direction polls alone
  assign lstat[0]   = !rx_empty;
  assign lstat[1]   = st.overrun;
  assign lstat[4:2] = rx_empty ? 3'h0 : rx_head[10:8];
  assign lstat[5]   = tx_empty;
  assign lstat[6]   = tx_empty && !tx_valid_o && tx_shift_empty_i;
  assign lstat[7]   = st.err_cnt != 7'h00;

  assign line_src  = ie_eff[IE_LINE_BIT] && (lstat[4:1] != 4'h0);
  assign rx_src    = ie_eff[IE_RX_BIT] && (fifo_on ? ({1'b0, rx_cnt} >= rx_trig) : !rx_empty);
  assign tx_src    = ie_eff[IE_TX_BIT] && st.tx_int;
  assign modem_src = ie_eff[IE_MODEM_BIT] && (st.delta != 4'h0);
  assign int_code  = line_src ? INT_CODE_LINE : rx_src ? INT_CODE_RX : tx_src ? INT_CODE_TX :
                     modem_src ? INT_CODE_MODEM : INT_CODE_NONE;
  assign istat     = {fifo_on, fifo_on, int_code};

  urc_fifo #(.W(RX_W)) u_rx_fifo (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clr_i     (rx_clr),
    .push_i    (rx_push),
    .data_i    ({rx_err_i, rx_data_i}),
    .pop_i     (rx_pop),
    .data_o    (rx_head),
    .count_o   (rx_cnt),
    .full_o    (rx_full),
    .empty_o   (rx_empty)
  );

  urc_fifo #(.W(TX_W)) u_tx_fifo (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clr_i     (tx_clr),
    .push_i    (tx_push),
    .data_i    (wdata_i),
    .pop_i     (tx_pop),
    .data_o    (tx_head),
    .count_o   (tx_cnt),
    .full_o    (tx_full),
    .empty_o   (tx_empty)
  );

  // A stalled transmit engine backs up into the FIFO instead of dropping a byte
  urc_buf2 #(.W(TX_W)) u_tx_buf (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .clr_i       (tx_clr),
    .in_valid_i  (tx_pop),
    .in_data_i   (tx_head),
    .in_ready_o  (buf_ready),
    .out_valid_o (tx_valid_o),
    .out_data_o  (tx_data_o),
    .out_ready_i (tx_ready_i)
  );

  always_comb
  begin
    logic [7:0] rd_val;
    rd_val = 8'h00;
    next_st = st;
    next_st.irq = int_code != INT_CODE_NONE;
    next_st.tx_need_q = tx_need;

    unique case (addr_i)
      3'h0: rd_val = enh ? (st.feature_control[FEAT_RX_SEL_BIT] ? {1'b0, rx_cnt} : {1'b0, tx_cnt}) :
                     div_sel ? ((divisor_o == 16'h0000) ? SILICON_REV : st.baud_divisor_low) :
                     rx_head[7:0];
      3'h1: rd_val = enh ? st.feature_control :
                     div_sel ? ((divisor_o == 16'h0000) ? PART_ID : st.baud_divisor_high) : ie_eff;
      3'h2: rd_val = enh ? st.enhanced_function : istat;
      3'h3: rd_val = st.line_control;
      3'h4: rd_val = enh ? st.flow_resume_char_1 : mctl_eff;
      3'h5: rd_val = enh ? st.flow_resume_char_2 : lstat;
      3'h6: rd_val = enh ? st.flow_pause_char_1 : {modem_lines_i, st.delta};
      3'h7: rd_val = enh ? st.flow_pause_char_2 : st.scratch;
    endcase
    if (rd_i)
      next_st.rdata = rd_val;

    // Clears first, so a same-cycle set below wins
    if ((rd_i && !enh && addr_i == ADDR_INT_STAT && int_code == INT_CODE_TX) || tx_push)
      next_st.tx_int = 1'b0;
    if ((tx_need && !st.tx_need_q) || (ie_tx_rise && tx_need))
      next_st.tx_int = 1'b1;
    if (rd_i && !enh && addr_i == ADDR_LINE_STAT)
      next_st.overrun = 1'b0;
    if (rx_valid_i && rx_full_eff)
      next_st.overrun = 1'b1;
    next_st.delta = ((rd_i && !enh && addr_i == ADDR_MODEM_STAT) ? 4'h0 : st.delta) | modem_delta_i;

    if (rx_clr)
      next_st.err_cnt = 7'h00;
    else
      next_st.err_cnt = st.err_cnt + {6'h00, rx_push && rx_err_i != 3'h0}
                        - {6'h00, rx_pop && rx_head[10:8] != 3'h0};

    if (wr_i && addr_i == ADDR_LINE_CTL)
      next_st.line_control = wdata_i;
    else if (wr_i && enh)
    begin
      unique case (addr_i)
        ADDR_TRIGGER:
          if (st.feature_control[FEAT_RX_SEL_BIT])
            next_st.rx_trigger_level = wdata_i;
          else
            next_st.tx_trigger_level = wdata_i;
        ADDR_FEATURE:  next_st.feature_control    = wdata_i;
        ADDR_ENH_FUNC: next_st.enhanced_function  = wdata_i;
        ADDR_RESUME_1: next_st.flow_resume_char_1 = wdata_i;
        ADDR_RESUME_2: next_st.flow_resume_char_2 = wdata_i;
        ADDR_PAUSE_1:  next_st.flow_pause_char_1  = wdata_i;
        ADDR_PAUSE_2:  next_st.flow_pause_char_2  = wdata_i;
        default: ;
      endcase
    end
    else if (wr_i && div_sel && addr_i == ADDR_DIV_LOW)
      next_st.baud_divisor_low = wdata_i;
    else if (wr_i && div_sel && addr_i == ADDR_DIV_HIGH)
      next_st.baud_divisor_high = wdata_i;
    else if (wr_i && norm && addr_i == ADDR_INT_EN)
      next_st.interrupt_enable_reg = wdata_i;
    else if (fctl_wr)
      // Other bits only program while the enable bit is written as one; resets self-clear
      next_st.fifo_control = wdata_i[FIFO_EN_BIT] ? (wdata_i & ~FIFO_CTL_RST_MASK) : REG_RST;
    else if (wr_i && !enh && addr_i == ADDR_MODEM_CTL)
      next_st.modem_control = wdata_i;
    else if (wr_i && !enh && addr_i == ADDR_SCRATCH)
      next_st.scratch = wdata_i;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      // Need starts high so that leaving reset is not taken as the holding position emptying
      st <= '{tx_need_q: 1'b1, default: '0};
    else
      st <= next_st;
  end

  assign rdata_o        = st.rdata;
  assign irq_o          = st.irq;
  assign divisor_o      = {st.baud_divisor_high, st.baud_divisor_low};
  assign line_control_o = st.line_control;

  AST_DIV_LOW_WRITE:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wr_i && div_sel && addr_i == ADDR_DIV_LOW |=> divisor_o[7:0] == $past(wdata_i))
    else $error("divisor low byte not written");
  AST_ENH_GATED:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rd_i && norm && addr_i == ADDR_INT_EN && !efr_on |=> rdata_o[7:4] == 4'h0)
    else $error("enhanced enable bits read back while gate shut");
  AST_RX_INT_RAISE:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      fifo_on && ie_eff[IE_RX_BIT] && {1'b0, rx_cnt} >= rx_trig |=> irq_o)
    else $error("receive trigger reached without interrupt");
  AST_RX_CODE_DROP:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      fifo_on && {1'b0, rx_cnt} < rx_trig |-> int_code != INT_CODE_RX)
    else $error("receive code shown below trigger");
  AST_DATA_READY:
    assert property (@(posedge sys_clk_i) disable iff (rst_i) rx_push |=> lstat[0])
    else $error("data ready not set after receive");
  AST_OVERRUN:
    assert property (@(posedge sys_clk_i) disable iff (rst_i) rx_valid_i && rx_full_eff |=> lstat[1])
    else $error("overrun not flagged");
  AST_HEAD_ERR_EMPTY:
    assert property (@(posedge sys_clk_i) disable iff (rst_i) rx_clr |=> lstat[4:2] == 3'h0)
    else $error("error bits shown with empty receive FIFO");
  AST_TX_NOT_EMPTY:
    assert property (@(posedge sys_clk_i) disable iff (rst_i) tx_push |=> !lstat[5] && !lstat[6])
    else $error("transmit empty after accepted write");
  AST_ERR_GLOBAL:
    assert property (@(posedge sys_clk_i) disable iff (rst_i) rx_push && rx_err_i != 3'h0 |=> lstat[7])
    else $error("errored character not flagged globally");
  AST_TX_INT_CLEAR:
    assert property (@(posedge sys_clk_i) disable iff (rst_i)
      tx_push && !(tx_need && !st.tx_need_q) |=> !st.tx_int)
    else $error("transmit interrupt not cleared by write");
  AST_TX_INT_ENABLE:
    assert property (@(posedge sys_clk_i) disable iff (rst_i) ie_tx_rise && tx_need |=> st.tx_int ##1 irq_o)
    else $error("transmit interrupt not raised on enable");
  AST_ERR_RESET:
    assert property (@(posedge sys_clk_i) disable iff (rst_i) rx_clr |=> !lstat[7])
    else $error("global error kept after FIFO reset");
endmodule : urc_uart_regs

// ---- core/urc_pkg.sv ----
// Shared constants for the UART channel register block
package urc_pkg;
  // Register addresses in normal mode
  localparam logic [2:0] ADDR_HOLD       = 3'h0;
  localparam logic [2:0] ADDR_INT_EN     = 3'h1;
  localparam logic [2:0] ADDR_INT_STAT   = 3'h2;
  localparam logic [2:0] ADDR_FIFO_CTL   = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTL   = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTL  = 3'h4;
  localparam logic [2:0] ADDR_LINE_STAT  = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STAT = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH    = 3'h7;
  // Divisor page
  localparam logic [2:0] ADDR_DIV_LOW    = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH   = 3'h1;
  // Enhanced page
  localparam logic [2:0] ADDR_TRIGGER    = 3'h0;
  localparam logic [2:0] ADDR_FEATURE    = 3'h1;
  localparam logic [2:0] ADDR_ENH_FUNC   = 3'h2;
  localparam logic [2:0] ADDR_RESUME_1   = 3'h4;
  localparam logic [2:0] ADDR_RESUME_2   = 3'h5;
  localparam logic [2:0] ADDR_PAUSE_1    = 3'h6;
  localparam logic [2:0] ADDR_PAUSE_2    = 3'h7;

  localparam logic [7:0] LINE_CTL_ENH_KEY = 8'hBF;
  localparam logic [7:0] REG_RST          = 8'h00;
  localparam int         DIV_EN_BIT       = 7;
  localparam int         ENH_EN_BIT       = 4;
  localparam int         FIFO_EN_BIT      = 0;
  localparam int         RX_RST_BIT       = 1;
  localparam int         TX_RST_BIT       = 2;
  localparam int         FEAT_RX_SEL_BIT  = 7;
  localparam int         IE_RX_BIT        = 0;
  localparam int         IE_TX_BIT        = 1;
  localparam int         IE_LINE_BIT      = 2;
  localparam int         IE_MODEM_BIT     = 3;
  localparam logic [7:0] IE_ENH_MASK      = 8'hF0;
  localparam logic [7:0] FIFO_CTL_ENH_MASK = 8'h30;
  localparam logic [7:0] MODEM_CTL_ENH_MASK = 8'hE0;
  localparam logic [7:0] FIFO_CTL_RST_MASK = 8'h06;
  localparam logic [1:0] TRIG_CUSTOM      = 2'h3;

  // Interrupt source codes, highest priority first
  localparam logic [5:0] INT_CODE_LINE    = 6'h06;
  localparam logic [5:0] INT_CODE_RX      = 6'h04;
  localparam logic [5:0] INT_CODE_TX      = 6'h02;
  localparam logic [5:0] INT_CODE_MODEM   = 6'h00;
  localparam logic [5:0] INT_CODE_NONE    = 6'h01;

  localparam int         FIFO_DEPTH       = 64;
  localparam int         FIFO_AW          = 6;
  localparam int         FIFO_CW          = 7;
  localparam logic [6:0] FIFO_FULL_CNT    = 7'h40;
  localparam int         RX_W             = 11;
  localparam int         TX_W             = 8;
  localparam logic [3:0][7:0] RX_TRIG_TAB = {8'h38, 8'h20, 8'h10, 8'h01};
  localparam logic [3:0][7:0] TX_TRIG_TAB = {8'h38, 8'h20, 8'h10, 8'h08};
endpackage : urc_pkg

// ---- core/urc_fifo.sv ----
// 64-entry synchronous FIFO with fill count and clear
`timescale 1ns/1ns
module urc_fifo
  import urc_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic               sys_clk_i,
  input  wire logic               rst_i,
  input  wire logic               clr_i,
  input  wire logic               push_i,
  input  wire logic [W-1:0]       data_i,
  input  wire logic               pop_i,
  output logic      [W-1:0]       data_o,
  output logic      [FIFO_CW-1:0] count_o,
  output logic                    full_o,
  output logic                    empty_o
);
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][W-1:0] mem;
    logic [FIFO_AW-1:0]           wp;
    logic [FIFO_AW-1:0]           rp;
    logic [FIFO_CW-1:0]           cnt;
  } urc_fifo_s;

  urc_fifo_s st;
  urc_fifo_s next_st;
  logic      do_push;
  logic      do_pop;

  assign full_o  = st.cnt == FIFO_FULL_CNT;
  assign empty_o = st.cnt == '0;
  assign count_o = st.cnt;
  assign data_o  = st.mem[st.rp];
  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;

  always_comb
  begin
    next_st = st;
    if (clr_i)
    begin
      next_st.wp  = '0;
      next_st.rp  = '0;
      next_st.cnt = '0;
    end
    else
    begin
      if (do_push)
      begin
        next_st.mem[st.wp] = data_i;
        next_st.wp         = st.wp + 6'h01;
      end
      if (do_pop)
        next_st.rp = st.rp + 6'h01;
      next_st.cnt = st.cnt + {6'h00, do_push} - {6'h00, do_pop};
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end
endmodule : urc_fifo

// ---- core/urc_buf2.sv ----
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ns
module urc_buf2
  import urc_pkg::*;
#(
  parameter int W = TX_W
)(
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic         clr_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic      [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);
  typedef struct packed {
    logic [1:0][W-1:0] d;
    logic [1:0]        v;
  } urc_buf_s;

  urc_buf_s st;
  urc_buf_s next_st;
  logic     pop;
  logic     push;

  assign out_valid_o = st.v[0];
  assign out_data_o  = st.d[0];
  assign in_ready_o  = !st.v[1];
  assign pop         = st.v[0] && out_ready_i;
  assign push        = in_valid_i && !st.v[1];

  always_comb
  begin
    next_st = st;
    if (clr_i)
      next_st.v = 2'h0;
    else
    begin
      if (pop)
      begin
        next_st.d[0] = st.d[1];
        next_st.v    = {1'b0, st.v[1]};
      end
      if (push && !next_st.v[0])
      begin
        next_st.d[0] = in_data_i;
        next_st.v[0] = 1'b1;
      end
      else if (push)
      begin
        next_st.d[1] = in_data_i;
        next_st.v[1] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end
endmodule : urc_buf2

// ---- sim/urc_tx_sink.sv ----
// Transmit engine model that takes bytes from the channel and shifts them out
`timescale 1ns/1ns
module urc_tx_sink
#(
  parameter int SHIFT_CYC = 4
)(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       stall_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o,
  output logic            shift_empty_o,
  output logic      [7:0] last_o,
  output logic      [7:0] cnt_o
);
  int busy;
  // Ready only while idle, so a stall backs the data up into the buffer
  assign tx_ready_o    = !stall_i && busy == 0;
  assign shift_empty_o = busy == 0;
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      busy   <= 0;
      last_o <= 8'h00;
      cnt_o  <= 8'h00;
    end
    else if (tx_valid_i && tx_ready_o)
    begin
      busy   <= SHIFT_CYC;
      last_o <= tx_data_i;
      cnt_o  <= cnt_o + 8'h01;
    end
    else if (busy != 0)
      busy <= busy - 1;
endmodule : urc_tx_sink

// ---- sim/urc_uart_regs_test.sv ----
// Self-checking bench for the UART channel register block
`timescale 1ns/1ns
module urc_uart_regs_test;
  import urc_pkg::*;
  localparam logic [7:0] REV_V = 8'h3C; // Arbitrary value
  localparam logic [7:0] PID_V = 8'h96; // Arbitrary value
  logic        sys_clk_i;
  logic        rst_i;
  logic [2:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic        irq_o;
  logic        rx_valid_i;
  logic [7:0]  rx_data_i;
  logic [2:0]  rx_err_i;
  logic        tx_valid_o;
  logic [7:0]  tx_data_o;
  logic        tx_ready_i;
  logic        tx_shift_empty_i;
  logic [15:0] divisor_o;
  logic [7:0]  line_control_o;
  logic        stall;
  logic [3:0]  mlines;
  logic [3:0]  mdelta;
  logic [7:0]  last;
  logic [7:0]  sent;
  int          failures;
  int          tests_run;
  int          cycles;

  urc_uart_regs #(.SILICON_REV(REV_V), .PART_ID(PID_V)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_err_i(rx_err_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .tx_shift_empty_i(tx_shift_empty_i),
    .modem_lines_i(mlines), .modem_delta_i(mdelta), .divisor_o(divisor_o), .line_control_o(line_control_o));
  urc_tx_sink sink_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .stall_i(stall), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i), .shift_empty_o(tx_shift_empty_i), .last_o(last),
    .cnt_o(sent));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task results;
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      results();
    end
  end

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(n, {8'h00, e}, {8'h00, rdata_o & m});
  endtask : rdc

  task push(input logic [7:0] d, input logic [2:0] e);
    @(posedge sys_clk_i);
    rx_valid_i <= 1'b1;
    rx_data_i  <= d;
    rx_err_i   <= e;
    @(posedge sys_clk_i);
    rx_valid_i <= 1'b0;
  endtask : push

  // Lets the fill count and the registered interrupt catch up
  task settle;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : settle

  task t_div;
    wr(ADDR_LINE_CTL, 8'h80);
    rdc(ADDR_DIV_LOW, 8'hFF, REV_V, "rev");
    rdc(ADDR_DIV_HIGH, 8'hFF, PID_V, "id");
    wr(ADDR_DIV_LOW, 8'h05);
    wr(ADDR_DIV_HIGH, 8'hA3);
    rdc(ADDR_DIV_LOW, 8'hFF, 8'h05, "div_lo");
    rdc(ADDR_DIV_HIGH, 8'hFF, 8'hA3, "div_hi");
    chk("divisor", 16'hA305, divisor_o);
    wr(ADDR_LINE_CTL, 8'h03);
    #1;
    chk("line_ctl", 16'h0003, {8'h00, line_control_o});
  endtask : t_div

  task t_enh;
    wr(ADDR_INT_EN, 8'hF0);
    rdc(ADDR_INT_EN, 8'hFF, 8'h00, "ie_off");
    wr(ADDR_LINE_CTL, LINE_CTL_ENH_KEY);
    wr(ADDR_ENH_FUNC, 8'h10);
    for (int i = 4; i < 8; i++)
      wr(i[2:0], 8'hA0 | i[7:0]);
    for (int i = 4; i < 8; i++)
      rdc(i[2:0], 8'hFF, 8'hA0 | i[7:0], "flow_char");
    wr(ADDR_LINE_CTL, 8'h03);
    rdc(ADDR_INT_EN, 8'hFF, 8'hF0, "ie_on");
    wr(ADDR_INT_EN, 8'h00);
  endtask : t_enh

  task t_rx;
    wr(ADDR_FIFO_CTL, 8'h41);
    wr(ADDR_INT_EN, 8'h01);
    rdc(ADDR_LINE_STAT, 8'h01, 8'h00, "ready_0");
    push(8'h00, 3'h0);
    rdc(ADDR_LINE_STAT, 8'h01, 8'h01, "ready_1");
    for (int i = 1; i < 15; i++)
      push(i[7:0], 3'h0);
    settle();
    chk("irq_15", 16'h0000, {15'h0000, irq_o});
    rdc(ADDR_INT_STAT, 8'hFF, 8'hC1, "stat_15");
    push(8'h0F, 3'h0);
    settle();
    chk("irq_16", 16'h0001, {15'h0000, irq_o});
    rdc(ADDR_INT_STAT, 8'hFF, 8'hC4, "stat_16");
    rdc(ADDR_HOLD, 8'hFF, 8'h00, "head");
    settle();
    chk("irq_drop", 16'h0000, {15'h0000, irq_o});
    rdc(ADDR_INT_STAT, 8'hFF, 8'hC1, "stat_drop");
    for (int i = 1; i < 16; i++)
      rdc(ADDR_HOLD, 8'hFF, i[7:0], "rx_byte");
    rdc(ADDR_LINE_STAT, 8'h01, 8'h00, "ready_empty");
  endtask : t_rx

  task t_err;
    wr(ADDR_INT_EN, 8'h00);
    push(8'h11, 3'h0);
    push(8'h22, 3'h4);
    settle();
    chk("irq_polled", 16'h0000, {15'h0000, irq_o});
    rdc(ADDR_LINE_STAT, 8'h9D, 8'h81, "err_global");
    rdc(ADDR_HOLD, 8'hFF, 8'h11, "err_head");
    rdc(ADDR_LINE_STAT, 8'h1C, 8'h10, "err_break");
    wr(ADDR_FIFO_CTL, 8'h43);
    rdc(ADDR_LINE_STAT, 8'h81, 8'h00, "err_reset");
    wr(ADDR_INT_EN, 8'h04);
    for (int i = 0; i < 65; i++)
      push(i[7:0], 3'h0);
    settle();
    chk("irq_overrun", 16'h0001, {15'h0000, irq_o});
    rdc(ADDR_INT_STAT, 8'hFF, 8'hC6, "stat_line");
    rdc(ADDR_LINE_STAT, 8'h02, 8'h02, "overrun");
    settle();
    chk("irq_line_clr", 16'h0000, {15'h0000, irq_o});
    rdc(ADDR_LINE_STAT, 8'h02, 8'h00, "overrun_clr");
    wr(ADDR_FIFO_CTL, 8'h43);
    wr(ADDR_INT_EN, 8'h00);
  endtask : t_err

  task t_modem;
    wr(ADDR_INT_EN, 8'h08);
    @(posedge sys_clk_i);
    mlines <= 4'hA;
    mdelta <= 4'h5;
    @(posedge sys_clk_i);
    mdelta <= 4'h0;
    settle();
    chk("irq_modem", 16'h0001, {15'h0000, irq_o});
    rdc(ADDR_INT_STAT, 8'hFF, 8'hC0, "stat_modem");
    rdc(ADDR_MODEM_STAT, 8'hFF, 8'hA5, "modem_stat");
    settle();
    chk("irq_modem_clr", 16'h0000, {15'h0000, irq_o});
    wr(ADDR_INT_EN, 8'h00);
  endtask : t_modem

  task t_tx;
    rdc(ADDR_LINE_STAT, 8'h60, 8'h60, "tx_empty");
    wr(ADDR_INT_EN, 8'h02);
    settle();
    chk("irq_tx", 16'h0001, {15'h0000, irq_o});
    rdc(ADDR_INT_STAT, 8'hFF, 8'hC2, "stat_tx");
    settle();
    chk("irq_tx_read", 16'h0000, {15'h0000, irq_o});
    wr(ADDR_INT_EN, 8'h00);
    wr(ADDR_INT_EN, 8'h02);
    settle();
    chk("irq_tx_again", 16'h0001, {15'h0000, irq_o});
    wr(ADDR_HOLD, 8'h00);
    settle();
    chk("irq_tx_write", 16'h0000, {15'h0000, irq_o});
    wr(ADDR_INT_EN, 8'h00);
    // Stalled sink: 64 in the FIFO plus 2 in the buffer, the rest is dropped
    for (int i = 1; i < 70; i++)
      wr(ADDR_HOLD, i[7:0]);
    rdc(ADDR_LINE_STAT, 8'h61, 8'h00, "tx_busy");
    @(posedge sys_clk_i);
    stall <= 1'b0;
    for (int n = 0; n < 3000 && !(sent == 8'h42 && tx_shift_empty_i); n++)
      @(posedge sys_clk_i);
    settle();
    chk("tx_count", 16'h0042, {8'h00, sent});
    chk("tx_last", 16'h0041, {8'h00, last});
    rdc(ADDR_LINE_STAT, 8'h60, 8'h60, "tx_idle");
  endtask : t_tx

  initial
  begin
    failures   = 0;
    tests_run  = 0;
    cycles     = 0;
    rst_i      = 1'b1;
    addr_i     = 3'h0;
    wdata_i    = 8'h00;
    wr_i       = 1'b0;
    rd_i       = 1'b0;
    rx_valid_i = 1'b0;
    rx_data_i  = 8'h00;
    rx_err_i   = 3'h0;
    stall      = 1'b1;
    mlines     = 4'h0;
    mdelta     = 4'h0;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk("reset_out", 16'h0000, {rdata_o, irq_o, tx_valid_o, line_control_o[5:0]});
    chk("reset_div", 16'h0000, divisor_o);
    t_div();
    t_enh();
    t_rx();
    t_err();
    t_modem();
    t_tx();
    results();
  end
endmodule : urc_uart_regs_test
